// File: fgm_frm_model.sv
/* Server framer model: pulls blocks, keeps their slot numbers.
 Assumes the mux clock; slow_i makes it take one cycle in three. */
`timescale 1ns/10ps
module fgm_frm_model (
	input wire logic	clk_i,
	input wire logic	slow_i,
	input wire logic	valid_i,
	input wire logic [9:0]	ts_i,
	input wire logic [15:0]	dat_i,
	output logic		ready_o
);
	logic [9:0]	got[$];
	logic [15:0]	dgot[$];
	int		cyc = 0;
	initial ready_o = 1'b0;
	// Record each taken block, then move ready just after the edge.
	always @(posedge clk_i) begin
		if (valid_i && ready_o) got.push_back(ts_i);
		if (valid_i && ready_o) dgot.push_back(dat_i);
		cyc++;
		ready_o <= #1 !slow_i || cyc % 3 == 0;
	end
endmodule // fgm_frm_model

// File: fgm_mux.sv
/*
 Fine grain slot multiframe mux. Rotates 16-byte payload blocks from the
 tributary mapper over the interleaved slots of the server payload and
 computes, per server frame, which slots own the four overhead positions.
 The slot owner of each overhead is placed with the mapper's justification
 overhead so it lands in the overhead area. Assumes the server framer gives
 one frame start pulse with the alignment counters and pulls blocks with a
 ready, all on ref_clk_i.
*/
//
// Overview of operation
// - OPU0 server carries 119 fine grain slots numbered 1 to 119.
// - OPU1 server carries 238 fine grain slots numbered 1 to 238.
// - OPU2 server carries 952 fine grain slots numbered 1 to 952.
// - Flexible server with n from 3 to 7 carries n times 119 slots.
// - Slots interleave in 16-byte blocks, rotating through every slot in order.
// - Each slot holds 256 blocks and one 12-bit overhead per multiframe.
// - Frames 1 to 29 of each set carry four overheads of consecutive slots.
// - Frame 30 of each set carries the last three overheads, fourth unused.
// - Frames 31 and 32 of each set carry no slot overhead.
// - Overhead positions fill in ascending slot order, four per frame.
// - OPU0 multiframe spans 32 frames indexed by alignment bits 4 to 8.
// - OPU1 multiframe spans 64 frames indexed by alignment bits 3 to 8.
// - OPU2 multiframe spans 256 frames indexed by alignment bits 1 to 8.
// - Tributaries arrive already asynchronously mapped by the upstream mapper.
// - Tributary units map synchronously into slots in whole 16-byte blocks.
// - Justification overhead goes to the overhead area, not the payload.
// - Flexible frame number is ((8*omfi + mfas[1:3]) mod n)*32 + mfas[4:8].
// - Multi-slot unit overhead rides in its highest allocated slot.

`timescale 1ns/10ps

module fgm_mux
	import fgm_pkg::*;
#(
	parameter int unsigned FLEX_N = FGM_FLEX_N_MIN
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  clk_en_i,
	input  wire fgm_srv_t              srv_type_i,
	input  wire logic                  frame_start_i,
	input  wire fgm_align_t            align_i,
	input  wire logic                  blk_valid_i,
	input  wire logic [FGM_BLOCK_W-1:0] blk_data_i,
	input  wire logic [FGM_TS_W-1:0]   unit_last_ts_i,
	input  wire logic [FGM_OH_W-1:0]   unit_oh_i,
	output logic                       blk_ready_o,
	input  wire logic                  srv_ready_i,
	output logic                       srv_valid_o,
	output fgm_blk_t                   srv_blk_o,
	output logic [7:0]                 frame_num_o,
	output fgm_ohpos_t [3:0]           oh_pos_o,
	output logic [3:0]                 oh_hit_o,
	output logic [FGM_OH_W-1:0]        oh_data_o
);

	// Elaboration check on the flexible server size.
	if (FLEX_N < FGM_FLEX_N_MIN || FLEX_N > FGM_FLEX_N_MAX) begin : g_bad_n
		$error("FLEX_N must lie between 3 and 7.");
	end

	// Number of sets in the multiframe for the chosen server.
	function automatic logic [3:0] sets_of(input fgm_srv_t s);
		case (s)
			FGM_SRV_OPU0: sets_of = 4'(FGM_SETS_OPU0);
			FGM_SRV_OPU1: sets_of = 4'(FGM_SETS_OPU1);
			FGM_SRV_OPU2: sets_of = 4'(FGM_SETS_OPU2);
			default:      sets_of = 4'(FLEX_N);
		endcase
	endfunction

	// Highest slot number: sets times 119.
	function automatic logic [FGM_TS_W-1:0] last_ts_of(input fgm_srv_t s);
		last_ts_of = FGM_TS_W'(FGM_SLOTS_PER_SET * sets_of(s));
	endfunction

	// Frame number inside the overhead multiframe, per server type.
	// The alignment byte is numbered 1..8 from the msb, so bits 4..8 are [4:0].
	logic [10:0] flex_idx;
	logic [2:0]  flex_set;
	logic [7:0]  frame_num_w;

	assign flex_idx = {align_i.omfi, 3'h0} + {8'h00, align_i.mfas[7:5]};
	assign flex_set = 3'(flex_idx % 11'(FLEX_N));

	always_comb begin
		case (srv_type_i)
			FGM_SRV_OPU0: frame_num_w = {3'h0, align_i.mfas[4:0]};
			FGM_SRV_OPU1: frame_num_w = {2'h0, align_i.mfas[5:0]};
			FGM_SRV_OPU2: frame_num_w = align_i.mfas;
			default:      frame_num_w = {flex_set, align_i.mfas[4:0]};
		endcase
	end

	// Overhead slot owners for the four positions of this frame.
	logic [2:0]          set_idx;
	logic [4:0]          fis;
	logic [FGM_TS_W-1:0] oh_base;
	fgm_ohpos_t [3:0]    oh_pos_w;

	assign set_idx = frame_num_w[7:5];
	assign fis     = frame_num_w[4:0];
	// Base slot of the frame, counting slots from one.
	assign oh_base = FGM_TS_W'(FGM_SLOTS_PER_SET * set_idx) + FGM_TS_W'({fis, 2'h0}) + FGM_TS_W'(1);

	for (genvar p = 0; p < 4; p++) begin : g_pos
		logic in_frame;
		// Positions 0..3 exist in frames 0..28; frame 29 keeps only three; 30, 31 none.
		assign in_frame = (fis < 5'(FGM_LAST_OH_FRAME)) ||
		                  (fis == 5'(FGM_LAST_OH_FRAME) && p < FGM_OH_IN_LAST);
		assign oh_pos_w[p].valid = in_frame;
		assign oh_pos_w[p].ts    = oh_base + FGM_TS_W'(p);
	end

	// Positions that carry the unit's justification overhead.
	logic [3:0] oh_hit_w;
	for (genvar h = 0; h < 4; h++) begin : g_hit
		assign oh_hit_w[h] = oh_pos_w[h].valid && (oh_pos_w[h].ts == unit_last_ts_i);
	end

	// Frame registers, refreshed at each frame start taken while clk_en_i is high.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			frame_num_o <= FGM_FRAME_RST;
			oh_pos_o    <= '0;
			oh_hit_o    <= '0;
			oh_data_o   <= '0;
		end else if (clk_en_i && frame_start_i) begin
			frame_num_o <= frame_num_w;
			oh_pos_o    <= oh_pos_w;
			oh_hit_o    <= oh_hit_w;
			oh_data_o   <= unit_oh_i;
		end
	end

	// Two-entry skid buffer between mapper and server framer.
	fgm_blk_t   buf_q [2];
	logic [1:0] cnt_q;
	logic       rd_q;
	logic       wr_q;
	logic       push;
	logic       pop;
	logic [FGM_TS_W-1:0] ts_q;
	logic [FGM_TS_W-1:0] ts_d;
	logic [FGM_TS_W-1:0] ts_last;

	assign push    = blk_valid_i && blk_ready_o;
	assign pop     = srv_valid_o && srv_ready_i;
	assign ts_last = last_ts_of(srv_type_i);
	// Slot counter wraps to slot one after the last slot; a frame start restarts it at slot one only in a cycle without a push.
	assign ts_d = (ts_q >= ts_last) ? FGM_TS_RST : ts_q + FGM_TS_W'(1);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ts_q <= FGM_TS_RST;
		end else if (clk_en_i) begin
			if (push) begin
				ts_q <= ts_d;
			end else if (frame_start_i) begin
				ts_q <= FGM_TS_RST;
			end
		end
	end

	// Storage writes; each entry is a whole 16-byte block.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else if (clk_en_i && push) begin
			buf_q[wr_q] <= '{ts: ts_q, data: blk_data_i};
		end
	end

	// Pointers and fill count.
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else if (clk_en_i) begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= cnt_q + 2'(push) - 2'(pop);
		end
	end

	// Registered outputs of the buffer, looking one step ahead.
	logic [1:0] cnt_d;
	logic       rd_d;
	assign cnt_d = cnt_q + 2'(push) - 2'(pop);
	assign rd_d  = pop ? ~rd_q : rd_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			blk_ready_o <= 1'b0;
			srv_valid_o <= 1'b0;
			srv_blk_o   <= '0;
		end else if (clk_en_i) begin
			blk_ready_o <= (cnt_d != 2'h2);
			srv_valid_o <= (cnt_d != 2'h0);
			if (cnt_d == 2'h0) begin
				srv_blk_o <= '0;
			end else if (push && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))) begin
				srv_blk_o <= '{ts: ts_q, data: blk_data_i};
			end else begin
				srv_blk_o <= buf_q[rd_d];
			end
		end
	end

endmodule // fgm_mux

// File: fgm_mux_properties.sv
/* Checker for fgm_mux frame and block outputs.
 Assumes one clock and a bind to every fgm_mux. */
`timescale 1ns/10ps
module fgm_mux_props
	import fgm_pkg::*;
#(
	parameter int unsigned FLEX_N = FGM_FLEX_N_MIN
) (
	input wire logic		ref_clk_i,
	input wire logic		rst_b_i,
	input wire logic		clk_en_i,
	input wire fgm_srv_t		srv_type_i,
	input wire logic		frame_start_i,
	input wire fgm_align_t		align_i,
	input wire logic [FGM_OH_W-1:0]	unit_oh_i,
	input wire logic		srv_ready_i,
	input wire logic		srv_valid_o,
	input wire fgm_blk_t		srv_blk_o,
	input wire logic [7:0]		frame_num_o,
	input wire fgm_ohpos_t [3:0]	oh_pos_o,
	input wire logic [FGM_OH_W-1:0]	oh_data_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Valid flags, frame in set and the frame start that the core takes.
	wire [3:0] vld = {oh_pos_o[3].valid, oh_pos_o[2].valid, oh_pos_o[1].valid, oh_pos_o[0].valid};
	wire [4:0] fis = frame_num_o[4:0];
	wire tk = frame_start_i && clk_en_i;
	opu0_frame_a: assert property (tk && srv_type_i == FGM_SRV_OPU0
		|=> frame_num_o == {3'h0, $past(align_i.mfas[4:0])}) else $error("opu0 frame");
	opu1_frame_a: assert property (tk && srv_type_i == FGM_SRV_OPU1
		|=> frame_num_o == {2'h0, $past(align_i.mfas[5:0])}) else $error("opu1 frame");
	opu2_frame_a: assert property (tk && srv_type_i == FGM_SRV_OPU2
		|=> frame_num_o == $past(align_i.mfas)) else $error("opu2 frame");
	full_frame_a: assert property ($past(tk) && fis < 5'h1d |-> vld == 4'hf) else $error("four overheads");
	last_frame_a: assert property (fis == 5'h1d |-> vld == 4'h7) else $error("three overheads");
	empty_frame_a: assert property (fis > 5'h1d |-> vld == 4'h0) else $error("no overheads");
	slot_num_a: assert property (vld[0] |-> oh_pos_o[0].ts == 119 * frame_num_o[7:5] + 4 * fis + 1)
		else $error("slot number");
	slot_order_a: assert property (vld[3] |-> oh_pos_o[3].ts == oh_pos_o[0].ts + 3) else $error("slot order");
	blk_hold_a: assert property (srv_valid_o && !srv_ready_i |=> srv_valid_o && $stable(srv_blk_o))
		else $error("block dropped");
	oh_copy_a: assert property (tk |=> oh_data_o == $past(unit_oh_i)) else $error("overhead copy");
	opu0_range_a: assert property (srv_valid_o && srv_type_i == FGM_SRV_OPU0
		|-> srv_blk_o.ts inside {[1:119]}) else $error("slot range");
	// Main scenarios seen.
	cover property (srv_valid_o && !srv_ready_i);
	cover property (vld == 4'h7);
	cover property (tk && srv_type_i == FGM_SRV_FLEX);
endmodule // fgm_mux_props
bind fgm_mux fgm_mux_props #(.FLEX_N(FLEX_N)) i_fgm_mux_props(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.clk_en_i(clk_en_i), .srv_type_i(srv_type_i), .frame_start_i(frame_start_i), .align_i(align_i),
	.unit_oh_i(unit_oh_i), .srv_ready_i(srv_ready_i), .srv_valid_o(srv_valid_o), .srv_blk_o(srv_blk_o),
	.frame_num_o(frame_num_o), .oh_pos_o(oh_pos_o), .oh_data_o(oh_data_o));

// File: fgm_pkg.sv
/*
 Package for the fine grain slot multiframe mux: server types, slot counts,
 overhead layout constants and the packed structs carried between stages.
 Assumes a single clock domain and a 128-bit (16-byte) payload block path.
*/
package fgm_pkg;

	// Slot geometry.
	localparam int unsigned FGM_SLOTS_PER_SET  = 119;
	localparam int unsigned FGM_FRAMES_PER_SET = 32;
	localparam int unsigned FGM_OH_PER_FRAME   = 4;
	localparam int unsigned FGM_LAST_OH_FRAME  = 29;
	localparam int unsigned FGM_OH_IN_LAST     = 3;
	localparam int unsigned FGM_BLOCKS_PER_TS  = 256;
	localparam int unsigned FGM_BLOCK_BYTES    = 16;
	localparam int unsigned FGM_BLOCK_W        = FGM_BLOCK_BYTES * 8;
	localparam int unsigned FGM_OH_W           = 12;
	localparam int unsigned FGM_TS_W           = 10;
	localparam int unsigned FGM_FLEX_N_MIN     = 3;
	localparam int unsigned FGM_FLEX_N_MAX     = 7;

	// Sets per multiframe for the fixed server rates.
	localparam int unsigned FGM_SETS_OPU0 = 1;
	localparam int unsigned FGM_SETS_OPU1 = 2;
	localparam int unsigned FGM_SETS_OPU2 = 8;

	// Reset values.
	localparam logic [FGM_TS_W-1:0] FGM_TS_RST    = 10'h001;
	localparam logic [7:0]          FGM_FRAME_RST = 8'h00;

	// Server payload kinds.
	typedef enum logic [1:0] {
		FGM_SRV_OPU0,
		FGM_SRV_OPU1,
		FGM_SRV_OPU2,
		FGM_SRV_FLEX
	} fgm_srv_t;

	// Frame position taken from the server framer.
	typedef struct packed {
		logic [7:0] mfas;
		logic [7:0] omfi;
	} fgm_align_t;

	// One payload block with the slot it belongs to.
	typedef struct packed {
		logic [FGM_TS_W-1:0]    ts;
		logic [FGM_BLOCK_W-1:0] data;
	} fgm_blk_t;

	// One slot overhead position of the current frame.
	typedef struct packed {
		logic                valid;
		logic [FGM_TS_W-1:0] ts;
	} fgm_ohpos_t;

endpackage : fgm_pkg

// File: tb_top.sv
/* Testbench for fgm_mux: overhead layout per frame and slot rotation.
 Assumes fgm_pkg, the checker and the framer model compile first. */
`timescale 1ns/10ps
module tb_top;
	import fgm_pkg::*;
	logic			ref_clk_i = 0, rst_b_i = 0, frame_start_i = 0, blk_valid_i = 0, slow = 0, clk_en_i = 1;
	logic [3:0]		oh_hit_o;
	fgm_srv_t		srv_type_i = FGM_SRV_OPU0;
	fgm_align_t		align_i = '0;
	logic [FGM_BLOCK_W-1:0]	blk_data_i = '0;
	logic [11:0]		unit_oh_i = 12'h000, oh_data_o;
	logic [9:0]		last_ts = 10'h072;
	logic			blk_ready_o, srv_ready_i, srv_valid_o;
	fgm_blk_t		srv_blk_o;
	logic [7:0]		frame_num_o;
	fgm_ohpos_t [3:0]	oh_pos_o;
	int			n_mismatch = 0, cmp_count = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	fgm_mux #(.FLEX_N(3)) i_fgm_mux(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
		.srv_type_i(srv_type_i), .frame_start_i(frame_start_i), .align_i(align_i), .blk_valid_i(blk_valid_i),
		.blk_data_i(blk_data_i), .unit_last_ts_i(last_ts), .unit_oh_i(unit_oh_i), .blk_ready_o(blk_ready_o),
		.srv_ready_i(srv_ready_i), .srv_valid_o(srv_valid_o), .srv_blk_o(srv_blk_o),
		.frame_num_o(frame_num_o), .oh_pos_o(oh_pos_o), .oh_hit_o(oh_hit_o), .oh_data_o(oh_data_o));
	fgm_frm_model i_fgm_frm_model(.clk_i(ref_clk_i), .slow_i(slow), .valid_i(srv_valid_o),
		.ts_i(srv_blk_o.ts), .dat_i(srv_blk_o.data[15:0]), .ready_o(srv_ready_i));
	task chk(string nm, logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One frame start, then the whole overhead layout of that frame.
	task t_frame(fgm_srv_t st, logic [7:0] mf, logic [7:0] om);
		int fn, f, s;
		srv_type_i = st;
		align_i = {mf, om};
		unit_oh_i = {om[3:0], mf};
		frame_start_i = 1;
		@(posedge ref_clk_i) #1 frame_start_i = 0;
		@(posedge ref_clk_i) #1;
		fn = st == FGM_SRV_OPU0 ? mf[4:0] : st == FGM_SRV_OPU1 ? mf[5:0] : st == FGM_SRV_OPU2 ? mf
			: ((8 * om + mf[7:5]) % 3) * 32 + mf[4:0];
		f = fn % 32;
		s = fn / 32;
		chk("frame", frame_num_o, fn);
		chk("oh data", oh_data_o, unit_oh_i);
		for (int p = 0; p < 4; p++) begin
			chk("oh valid", oh_pos_o[p].valid, f < 29 || (f == 29 && p < 3));
			if (f < 29 || (f == 29 && p < 3)) chk("oh slot", oh_pos_o[p].ts, 119 * s + 4 * f + 1 + p);
			chk("oh hit", oh_hit_o[p], (f < 29 || (f == 29 && p < 3)) && (119 * s + 4 * f + 1 + p == last_ts));
		end
	endtask
	// A frame start while the clock enable is low must leave the frame number alone.
	task t_freeze;
		logic [7:0] fn0;
		fn0 = frame_num_o;
		clk_en_i = 0;
		align_i = {8'h05, 8'h00};
		frame_start_i = 1;
		@(posedge ref_clk_i) #1 frame_start_i = 0;
		@(posedge ref_clk_i) #1 chk("frozen", frame_num_o, fn0);
		clk_en_i = 1;
	endtask
	// Push n blocks back to back and check the slot of each delivered block.
	task t_blocks(fgm_srv_t st, int sets, int n, logic sl);
		int k, full;
		k = 0;
		full = 0;
		slow = sl;
		i_fgm_frm_model.got.delete();
		i_fgm_frm_model.dgot.delete();
		t_frame(st, 8'h00, 8'h00);
		blk_valid_i = 1;
		while (k < n) begin
			blk_data_i = k;
			@(posedge ref_clk_i);
			if (blk_ready_o) k++;
			else full = 1;
			#1;
		end
		blk_valid_i = 0;
		for (int w = 0; w < 200 && i_fgm_frm_model.got.size() < n; w++) @(posedge ref_clk_i);
		#1 chk("count", i_fgm_frm_model.got.size(), n);
		chk("refused", full, sl);
		foreach (i_fgm_frm_model.got[i]) chk("slot", i_fgm_frm_model.got[i], i % (119 * sets) + 1);
		foreach (i_fgm_frm_model.dgot[i]) chk("data", i_fgm_frm_model.dgot[i], i);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#1 rst_b_i = 1;
		@(posedge ref_clk_i) #1;
		t_frame(FGM_SRV_OPU0, 8'h1c, 8'h00);
		t_frame(FGM_SRV_OPU0, 8'h1d, 8'h00);
		t_frame(FGM_SRV_OPU0, 8'h1e, 8'h00);
		t_frame(FGM_SRV_OPU1, 8'hbd, 8'h00);
		t_frame(FGM_SRV_OPU2, 8'hff, 8'h00);
		t_frame(FGM_SRV_OPU2, 8'he3, 8'h00);
		t_frame(FGM_SRV_FLEX, 8'h41, 8'h01);
		t_freeze();
		t_blocks(FGM_SRV_OPU0, 1, 121, 0);
		t_blocks(FGM_SRV_OPU1, 2, 240, 1);
		t_blocks(FGM_SRV_OPU2, 8, 954, 0);
		t_blocks(FGM_SRV_FLEX, 3, 360, 1);
		stop_test();
	end
	// Cuts a hang short.
	initial begin
		#40000;
		n_mismatch++;
		stop_test();
	end
endmodule // tb_top
